// File: sss_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz control clock, 32-bit register bus
// Notes: definitions only
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

`define SSS_CLK_NS 100
`define SSS_TICK_NS 100000000
`define SSS_TICK_CYCLES ((`SSS_TICK_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)

`define SSS_OFF_CTRL 8'h00
`define SSS_OFF_DIR 8'h04
`define SSS_OFF_STAT 8'h08
`define SSS_OFF_SPD 8'h40
`define SSS_OFF_DUR 8'h80

`define SSS_NSEG 15
`define SSS_LAST_SEG 4'hF
`define SSS_FIRST_SEG 4'h1

`define SSS_CTRL_MEM 0
`define SSS_CTRL_EN 1
`define SSS_CTRL_PAT 4

`define SSS_SPD_RST0 16'h03E8
`define SSS_SPD_STEP 16'h01F4
`define SSS_SPD_RAMP 9
`define SSS_DUR_RST 14'h03E8
`define SSS_DUR_RST_N 5
`define SSS_DUR_MAX 14'h270F
`define SSS_MAX_FREQ 16'h9C40

`define SSS_RESP_OK 2'h0
`define SSS_RESP_ERR 2'h2

`endif

// File: sss_pkg.sv
// Purpose: types shared by the speed segment sequencer
// Assumes: nothing
// Notes: one-hot states, run patterns, speed source levels
package sss_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_PAUSE = 4'h4,
        ST_HOLD = 4'h8
    } sss_state_t;

    typedef enum logic [2:0] {
        PAT_ONCE = 3'h0,
        PAT_ONCE_PAUSE = 3'h1,
        PAT_CYCLE = 3'h2,
        PAT_CYCLE_PAUSE = 3'h3,
        PAT_HOLD = 3'h4
    } sss_pat_t;

    typedef enum logic [2:0] {
        SRC_JOG = 3'h1,
        SRC_EXT_MS = 3'h2,
        SRC_INTERNAL = 3'h3,
        SRC_PID = 3'h4,
        SRC_TRIANGLE = 3'h5,
        SRC_WINDING = 3'h6,
        SRC_NORMAL = 3'h7
    } sss_src_t;

endpackage : sss_pkg

// File: sss_seg_timer.sv
// Purpose: segment duration timer in 0.1 s ticks
// Assumes: clear pulses at each segment entry
// Notes: count freezes while run is low
`timescale 1ns/100ps
`default_nettype none
`include "sss_map.svh"

module sss_seg_timer #(
    parameter int TICK_CYCLES = `SSS_TICK_CYCLES,
    parameter int DUR_W = 14
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic run,
    input wire logic [DUR_W-1:0] duration,
    output logic expired
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_q, pre_d;
    logic [DUR_W-1:0] ela_q, ela_d;

    assign expired = run && (ela_q >= duration);

    always_comb begin
        pre_d = pre_q;
        ela_d = ela_q;
        if (clear) begin
            pre_d = '0;
            ela_d = '0;
        end else if (run && !expired) begin
            if (pre_q == PRE_LAST) begin
                pre_d = '0;
                ela_d = ela_q + 1'b1;
            end else begin
                pre_d = pre_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= '0;
            ela_q <= '0;
        end else begin
            pre_q <= pre_d;
            ela_q <= ela_d;
        end
    end

endmodule : sss_seg_timer
`default_nettype wire

// File: sss_sequencer.sv
// Purpose: fifteen-segment internal speed program sequencer
// Assumes: terminal pins are asynchronous; AXI4-Lite register slave
// Notes: speeds in 0.01 Hz, durations in 0.1 s
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sss_map.svh"

module sss_sequencer
    import sss_pkg::*;
#(
    parameter int TICK_CYCLES = `SSS_TICK_CYCLES,
    parameter logic [15:0] MAX_FREQ = `SSS_MAX_FREQ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic seq_start_pin,
    input wire logic seq_stop_pin,
    input wire logic fault_pin,
    input wire logic zero_speed_pin,
    input wire logic run_rev_pin,
    input wire logic [6:0] src_req_pin,
    output logic seq_active,
    output logic [15:0] out_freq,
    output logic out_rev,
    output logic [2:0] out_src,
    output logic [3:0] out_seg
);
    localparam int NS = `SSS_NSEG;

    function automatic logic [4:0] idx_of(logic [7:0] a, logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        idx_of = 5'h1F;
        if (a >= base && off[1:0] == 2'h0 && off[7:2] < 6'(NS))
            idx_of = off[6:2];
    endfunction : idx_of

    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                          logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++)
            if (s[b])
                merge[b*8 +: 8] = n[b*8 +: 8];
    endfunction : merge

    function automatic sss_src_t pick_src(logic [6:0] req);
        pick_src = SRC_NORMAL;
        for (int i = 6; i >= 0; i--)
            if (req[i])
                pick_src = sss_src_t'(3'(i + 1));
    endfunction : pick_src

    // pin synchronisers
    logic [11:0] sync1_q, sync2_q;
    logic start_prev_q;
    logic start_s, stop_s, fault_s, zero_s, rev_s;
    logic [6:0] req_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            start_prev_q <= 1'b0;
        end else begin
            sync1_q <= {src_req_pin, run_rev_pin, zero_speed_pin, fault_pin,
                        seq_stop_pin, seq_start_pin};
            sync2_q <= sync1_q;
            start_prev_q <= start_s;
        end
    end
    assign {req_s, rev_s, zero_s, fault_s, stop_s, start_s} = sync2_q;

    // register bus
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire;

    logic mem_q, mem_d, en_q, en_d;
    logic [2:0] pat_q, pat_d;
    logic [15:0] dir_q, dir_d;
    logic [15:0] spd_q [NS], spd_d [NS];
    logic [13:0] dur_q [NS], dur_d [NS];

    sss_state_t state_q, state_d;
    logic [3:0] seg_q, seg_d;
    logic freq_zero_q;
    logic tclr, expired;
    logic seq_active_q, seq_active_d, out_rev_q, out_rev_d;
    logic [15:0] out_freq_q, out_freq_d;
    logic [2:0] out_src_q, out_src_d;

    always_comb begin
        logic [31:0] m;
        logic [4:0] wi, wd, ri, rd;
        m = '0;
        wi = idx_of(awaddr_q, `SSS_OFF_SPD);
        wd = idx_of(awaddr_q, `SSS_OFF_DUR);
        ri = idx_of(s_axi_araddr, `SSS_OFF_SPD);
        rd = idx_of(s_axi_araddr, `SSS_OFF_DUR);
        aw_ok_d = aw_ok_q;
        awaddr_d = awaddr_q;
        w_ok_d = w_ok_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        mem_d = mem_q;
        en_d = en_q;
        pat_d = pat_q;
        dir_d = dir_q;
        spd_d = spd_q;
        dur_d = dur_q;
        wr_fire = aw_ok_q && w_ok_q && !bvalid_q;
        if (s_axi_awvalid && awready_q) begin
            aw_ok_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_ok_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (wr_fire) begin
            aw_ok_d = 1'b0;
            w_ok_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `SSS_RESP_OK;
            if (awaddr_q == `SSS_OFF_CTRL) begin
                m = merge({25'h0, pat_q, 2'h0, en_q, mem_q}, wdata_q, wstrb_q);
                mem_d = m[`SSS_CTRL_MEM];
                en_d = m[`SSS_CTRL_EN];
                pat_d = m[`SSS_CTRL_PAT +: 3];
            end else if (awaddr_q == `SSS_OFF_DIR) begin
                m = merge({16'h0, dir_q}, wdata_q, wstrb_q);
                dir_d = m[15:0];
            end else if (wi != 5'h1F) begin
                m = merge({16'h0, spd_q[wi[3:0]]}, wdata_q, wstrb_q);
                spd_d[wi[3:0]] = (m[15:0] > MAX_FREQ) ? MAX_FREQ : m[15:0];
            end else if (wd != 5'h1F) begin
                m = merge({18'h0, dur_q[wd[3:0]]}, wdata_q, wstrb_q);
                dur_d[wd[3:0]] = (m[15:0] > {2'h0, `SSS_DUR_MAX}) ?
                                 `SSS_DUR_MAX : m[13:0];
            end else if (awaddr_q != `SSS_OFF_STAT) begin
                bresp_d = `SSS_RESP_ERR;
            end
        end
        awready_d = !aw_ok_d && !bvalid_d;
        wready_d = !w_ok_d && !bvalid_d;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = `SSS_RESP_OK;
            rdata_d = '0;
            if (s_axi_araddr == `SSS_OFF_CTRL)
                rdata_d = {25'h0, pat_q, 2'h0, en_q, mem_q};
            else if (s_axi_araddr == `SSS_OFF_DIR)
                rdata_d = {16'h0, dir_q};
            else if (s_axi_araddr == `SSS_OFF_STAT)
                rdata_d = {out_freq_q, 4'h0, out_rev_q, out_src_q,
                           state_q, seg_q};
            else if (ri != 5'h1F)
                rdata_d = {16'h0, spd_q[ri[3:0]]};
            else if (rd != 5'h1F)
                rdata_d = {18'h0, dur_q[rd[3:0]]};
            else
                rresp_d = `SSS_RESP_ERR;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `SSS_RESP_OK;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `SSS_RESP_OK;
            mem_q <= 1'b0;
            en_q <= 1'b0;
            pat_q <= PAT_ONCE;
            dir_q <= 16'h0;
            for (int i = 0; i < NS; i++) begin
                spd_q[i] <= (i < `SSS_SPD_RAMP) ?
                    16'(`SSS_SPD_RST0 + i * `SSS_SPD_STEP) : `SSS_SPD_RST0;
                dur_q[i] <= (i < `SSS_DUR_RST_N) ? `SSS_DUR_RST : 14'h0;
            end
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_ok_q <= aw_ok_d;
            w_ok_q <= w_ok_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            mem_q <= mem_d;
            en_q <= en_d;
            pat_q <= pat_d;
            dir_q <= dir_d;
            spd_q <= spd_d;
            dur_q <= dur_d;
        end
    end

    // segment sequencing
    logic start_pulse, stop_evt, busy;
    assign start_pulse = start_s && !start_prev_q;
    assign stop_evt = stop_s || fault_s || !en_q;
    assign busy = state_q != ST_IDLE;

    sss_seg_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .DUR_W(14)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .clear(tclr),
        .run(state_q == ST_RUN),
        .duration(dur_q[seg_q - `SSS_FIRST_SEG]),
        .expired(expired)
    );

    always_comb begin
        state_d = state_q;
        seg_d = seg_q;
        tclr = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (start_pulse && !stop_evt)
                    state_d = ST_RUN;
            end
            ST_RUN: begin
                if (stop_evt) begin
                    state_d = ST_IDLE;
                    if (!mem_q) begin
                        seg_d = `SSS_FIRST_SEG;
                        tclr = 1'b1;
                    end
                end else if (expired) begin
                    tclr = 1'b1;
                    if (seg_q == `SSS_LAST_SEG) begin
                        seg_d = `SSS_FIRST_SEG;
                        unique case (pat_q)
                            PAT_CYCLE: state_d = ST_RUN;
                            PAT_CYCLE_PAUSE: state_d = ST_PAUSE;
                            PAT_HOLD: begin
                                state_d = ST_HOLD;
                                seg_d = seg_q;
                            end
                            default: state_d = ST_IDLE;
                        endcase
                    end else begin
                        seg_d = seg_q + 4'h1;
                        if (pat_q == PAT_ONCE_PAUSE ||
                            pat_q == PAT_CYCLE_PAUSE)
                            state_d = ST_PAUSE;
                    end
                end
            end
            ST_PAUSE: begin
                if (stop_evt) begin
                    state_d = ST_IDLE;
                    if (!mem_q)
                        seg_d = `SSS_FIRST_SEG;
                end else if (zero_s && freq_zero_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (stop_evt) begin
                    state_d = ST_IDLE;
                    seg_d = `SSS_FIRST_SEG;
                end
            end
        endcase
    end

    always_comb begin
        out_src_d = pick_src({req_s[6:3], busy && en_q, req_s[1:0]});
        out_freq_d = 16'h0;
        if ((state_q == ST_RUN || state_q == ST_HOLD) &&
            out_src_d == SRC_INTERNAL)
            out_freq_d = spd_q[seg_q - `SSS_FIRST_SEG];
        if (!en_q)
            out_rev_d = rev_s;
        else if (busy)
            out_rev_d = dir_q[seg_q];
        else
            out_rev_d = dir_q[0];
        seq_active_d = en_q && busy;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            seg_q <= `SSS_FIRST_SEG;
            freq_zero_q <= 1'b1;
            seq_active_q <= 1'b0;
            out_freq_q <= 16'h0;
            out_rev_q <= 1'b0;
            out_src_q <= SRC_NORMAL;
        end else begin
            state_q <= state_d;
            seg_q <= seg_d;
            freq_zero_q <= out_freq_q == 16'h0;
            seq_active_q <= seq_active_d;
            out_freq_q <= out_freq_d;
            out_rev_q <= out_rev_d;
            out_src_q <= out_src_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign seq_active = seq_active_q;
    assign out_freq = out_freq_q;
    assign out_rev = out_rev_q;
    assign out_src = out_src_q;
    assign out_seg = seg_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    mem_off_a: assert property (state_q == ST_RUN && stop_evt && !mem_q
        |=> seg_q == `SSS_FIRST_SEG && state_q == ST_IDLE)
        else $error("position kept with memory off");
    mem_on_a: assert property (state_q == ST_RUN && stop_evt && mem_q
        |=> seg_q == $past(seg_q) && state_q == ST_IDLE)
        else $error("position lost with memory on");
    power_on_a: assert property (disable iff (1'b0) rst
        |=> state_q == ST_IDLE && seg_q == `SSS_FIRST_SEG)
        else $error("reset did not restore initial state");
    disabled_idle_a: assert property (!en_q [*2] |-> !seq_active_q)
        else $error("sequencer active while disabled");
    start_run_a: assert property (state_q == ST_IDLE && start_pulse &&
        !stop_evt |=> state_q == ST_RUN ##1 seq_active_q)
        else $error("start not honoured");
    jog_first_a: assert property (req_s[0] |=> out_src_q == SRC_JOG)
        else $error("jog not selected first");
    cycle_wrap_a: assert property (state_q == ST_RUN && expired &&
        !stop_evt && seg_q == `SSS_LAST_SEG && pat_q == PAT_CYCLE
        |=> state_q == ST_RUN && seg_q == `SSS_FIRST_SEG)
        else $error("continuous cycle did not wrap");
    pause_zero_a: assert property (state_q == ST_PAUSE |=>
        out_freq_q == 16'h0)
        else $error("speed not zero in pause");
    hold_last_a: assert property (state_q == ST_RUN && expired &&
        !stop_evt && seg_q == `SSS_LAST_SEG && pat_q == PAT_HOLD
        |=> state_q == ST_HOLD && seg_q == `SSS_LAST_SEG)
        else $error("hold pattern did not keep last segment");
    freq_max_a: assert property (out_freq_q <= MAX_FREQ)
        else $error("output speed above maximum");
    seg_dir_a: assert property (en_q && busy && $stable(en_q)
        |=> out_rev_q == $past(dir_q[seg_q]))
        else $error("segment direction not applied");
    advance_a: assert property (state_q == ST_RUN && expired && !stop_evt
        && seg_q != `SSS_LAST_SEG |=> seg_q == $past(seg_q) + 4'h1)
        else $error("segment did not advance");

    pause_seen_c: cover property (state_q == ST_RUN ##1 state_q == ST_PAUSE);
    hold_seen_c: cover property (state_q == ST_HOLD);
    resume_seen_c: cover property (state_q == ST_IDLE &&
        seg_q != `SSS_FIRST_SEG ##1 state_q == ST_RUN);

endmodule : sss_sequencer
`default_nettype wire

// File: sss_drive_model.sv
// Purpose: drive-side model that reports zero output speed
// Assumes: zero speed is reached LAG cycles after the command hits 0
// Notes: any nonzero command clears the flag on the next clock edge
`timescale 1ns/100ps
`default_nettype none
module sss_drive_model #(
    parameter int LAG = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] out_freq,
    output logic zero_speed_pin
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (out_freq != 16'h0000) cnt_d = 8'h00;
        else if (cnt_q < 8'(LAG)) cnt_d = cnt_q + 8'h01;
    end
    always_ff @(posedge clk) begin
        if (rst) cnt_q <= 8'h00;
        else cnt_q <= cnt_d;
    end
    // motor coasts down before zero speed is reported
    assign zero_speed_pin = (cnt_q >= 8'(LAG));
endmodule : sss_drive_model
`default_nettype wire

// File: speed_segment_sequencer_bench.sv
// Purpose: register and terminal driven test of the sequencer
// Assumes: tick shortened to 4 cycles, so one duration unit is 4 cycles
// Notes: every wait is bounded and ends the run when it expires
`timescale 1ns/100ps
`default_nettype none
`include "sss_map.svh"
module speed_segment_sequencer_bench;
    logic clk, rst;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb, out_seg;
    logic [1:0] bresp, rresp, rs_v;
    logic start_p, stop_p, fault_p, zero_p, rev_p, seq_active, out_rev;
    logic [6:0] src_p;
    logic [15:0] out_freq;
    logic [2:0] out_src;
    logic [6:0] req [3] = '{7'h7F, 7'h7E, 7'h7C};
    int bad_count, checks_done, i;

    sss_sequencer #(.TICK_CYCLES(4)) sss_sequencer_i (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .seq_start_pin(start_p), .seq_stop_pin(stop_p),
        .fault_pin(fault_p), .zero_speed_pin(zero_p),
        .run_rev_pin(rev_p), .src_req_pin(src_p),
        .seq_active(seq_active), .out_freq(out_freq), .out_rev(out_rev),
        .out_src(out_src), .out_seg(out_seg)
    );
    sss_drive_model sss_drive_model_i (
        .clk(clk), .rst(rst), .out_freq(out_freq), .zero_speed_pin(zero_p)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task give_verdict;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task hang;
        chk(32'h0, 32'h1);
        give_verdict();
    endtask : hang

    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask : rd

    task w(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rs_v);
        if (rs_v !== `SSS_RESP_OK) chk(rs_v, `SSS_RESP_OK);
    endtask : w

    task rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, rd_v, rs_v);
        chk(rd_v, exp);
    endtask : rc

    // 0 idle, 1 active, 2 paused, 3 segment v, other: frequency v
    task wt(input int k, input logic [15:0] v);
        int n;
        logic hit;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            case (k)
                0: hit = (seq_active === 1'b0);
                1: hit = (seq_active === 1'b1);
                2: hit = (seq_active === 1'b1 && out_freq === 16'h0000);
                3: hit = (out_seg === v[3:0]);
                default: hit = (out_freq === v);
            endcase
            if (hit) break;
        end
        if (n == 3000) hang();
    endtask : wt

    task go;
        @(posedge clk);
        start_p <= 1'b1;
        repeat (4) @(posedge clk);
        start_p <= 1'b0;
        wt(1, 16'h0);
    endtask : go

    task halt(input logic f);
        @(posedge clk);
        if (f) fault_p <= 1'b1;
        else stop_p <= 1'b1;
        wt(0, 16'h0);
        fault_p <= 1'b0;
        stop_p <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : halt

    initial begin
        rst = 1'b1;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, start_p, stop_p, fault_p, rev_p, src_p} = '0;
        wstrb = 4'hF;
        bad_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rc(`SSS_OFF_CTRL, 32'h0);
        rc(`SSS_OFF_SPD + 8'h20, 32'h1388);
        rc(`SSS_OFF_SPD + 8'h24, 32'h03E8);
        rc(`SSS_OFF_DUR + 8'h10, 32'h03E8);
        rc(`SSS_OFF_DUR + 8'h14, 32'h0);
        rc(`SSS_OFF_STAT, 32'h0711);
        rd(8'h30, rd_v, rs_v);
        chk(rs_v, `SSS_RESP_ERR);
        wr(8'h3C, 32'h1, rs_v);
        chk(rs_v, `SSS_RESP_ERR);
        w(`SSS_OFF_SPD + 8'h08, 32'hFFFF);
        rc(`SSS_OFF_SPD + 8'h08, `SSS_MAX_FREQ);
        w(`SSS_OFF_DUR + 8'h08, 32'h3FFF);
        rc(`SSS_OFF_DUR + 8'h08, 32'h270F);
        for (i = 2; i < 5; i++) w(`SSS_OFF_DUR + 8'(4 * i), 32'h0);
        w(`SSS_OFF_DUR, 32'd20);
        w(`SSS_OFF_DUR + 8'h04, 32'd6);
        w(`SSS_OFF_SPD, 32'h0100);
        w(`SSS_OFF_SPD + 8'h04, 32'h0200);
        w(`SSS_OFF_SPD + 8'h38, 32'h0ABC);
        w(`SSS_OFF_DIR, 32'h8002);
        w(`SSS_OFF_CTRL, 32'h40);
        start_p <= 1'b1;
        rev_p <= 1'b1;
        repeat (8) @(posedge clk);
        start_p <= 1'b0;
        chk(seq_active, 1'b0);
        chk(out_src, 3'h7);
        chk(out_rev, 1'b1);
        rev_p <= 1'b0;
        w(`SSS_OFF_CTRL, 32'h02);
        go();
        repeat (2) @(posedge clk);
        chk(out_seg, 4'h1);
        chk(out_freq, 16'h0100);
        chk(out_rev, 1'b1);
        chk(out_src, 3'h3);
        for (i = 0; i < 3; i++) begin
            src_p <= req[i];
            repeat (4) @(posedge clk);
            chk(out_src, 3'(i + 1));
        end
        src_p <= 7'h00;
        wt(3, 16'h2);
        repeat (2) @(posedge clk);
        chk(out_freq, 16'h0200);
        chk(out_rev, 1'b0);
        wt(0, 16'h0);
        chk(seq_active, 1'b0);
        rev_p <= 1'b1;
        repeat (4) @(posedge clk);
        chk(out_rev, 1'b0);
        rev_p <= 1'b0;
        w(`SSS_OFF_CTRL, 32'h22);
        go();
        wt(3, 16'hF);
        wt(3, 16'h1);
        chk(seq_active, 1'b1);
        halt(1'b0);
        w(`SSS_OFF_CTRL, 32'h42);
        go();
        wt(3, 16'hF);
        repeat (10) @(posedge clk);
        chk(seq_active, 1'b1);
        chk(out_freq, 16'h0ABC);
        chk(out_rev, 1'b1);
        halt(1'b0);
        for (i = 1; i < 4; i += 2) begin
            w(`SSS_OFF_CTRL, 32'(i * 16 + 2));
            go();
            wt(2, 16'h0);
            wt(4, 16'h0200);
            chk(out_seg, 4'h2);
            halt(1'b0);
        end
        for (i = 0; i < 2; i++) begin
            w(`SSS_OFF_CTRL, 32'(2 + i));
            go();
            wt(3, 16'h2);
            halt(i[0]);
            go();
            repeat (2) @(posedge clk);
            chk(out_seg, i ? 4'h2 : 4'h1);
            halt(1'b0);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(out_seg, 4'h1);
        rc(`SSS_OFF_CTRL, 32'h0);
        give_verdict();
    end
endmodule : speed_segment_sequencer_bench
`default_nettype wire
